/* File: sim/warning_event_logger_bench.sv */
// Self-checking bench of the warning and event logger
`timescale 1ns/1ps
`include "wel_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("mismatch at %0t: got %0h want %0h", $time, a, b); end end
module warning_event_logger_bench;
   typedef struct packed {logic [3:0] kind; logic [7:0] code; logic pop; logic [1:0] led;} wel_row_t;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0]  addr_i = 8'h00, warn_code_o, ec, pc;
   logic [31:0] wdata_i = 32'h0, stamp_i = 32'h0, rdata_o, lcd_stamp_o, st, seen_stamp;
   logic [8:0]  src1_det_i = 9'h000, src2_det_i = 9'h000;
   logic [1:0]  conn_i = 2'h3, test_fail_i = 2'h0, led_o;
   logic        gen_start_i = 1'b0, gen_rdy_i = 1'b0, aux_pwr_i = 1'b0, popup_o, pe, l0;
   logic [2:0]  mode_i = 3'h5;
   logic [6:0]  lcd_idx_i, want = 7'h00;
   logic [15:0] thr_o, lcd_info_o, inf, seen_info;
   int          error_cnt = 0, comparisons = 0, cycles = 0;
   // Kind, code of first source, pop-up expected, LED: 0 off, 1 on, 2 blink, 3 any
   wel_row_t rows [9] = '{'{4'd0, 8'h32, 1'b1, 2'd3}, '{4'd1, 8'h34, 1'b1, 2'd3}, '{4'd2, 8'h36, 1'b0, 2'd2},
      '{4'd3, 8'h46, 1'b0, 2'd2}, '{4'd4, 8'h48, 1'b0, 2'd2}, '{4'd5, 8'h4a, 1'b0, 2'd0},
      '{4'd6, 8'h4c, 1'b0, 2'd2}, '{4'd7, 8'h4e, 1'b0, 2'd2}, '{4'd8, 8'h50, 1'b0, 2'd1}};

   wel_top #(.GEN_CYC(20), .BLINK_CYC(4)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src1_det_i(src1_det_i),
      .src2_det_i(src2_det_i), .conn_i(conn_i), .test_fail_i(test_fail_i), .gen_start_i(gen_start_i),
      .gen_rdy_i(gen_rdy_i), .aux_pwr_i(aux_pwr_i), .stamp_i(stamp_i), .mode_i(mode_i), .lcd_idx_i(lcd_idx_i),
      .popup_o(popup_o), .warn_code_o(warn_code_o), .led_o(led_o), .thr_o(thr_o),
      .lcd_stamp_o(lcd_stamp_o), .lcd_info_o(lcd_info_o));
   wel_panel_model i_panel (.clk_i(clk_i), .want_i(want), .stamp_i(lcd_stamp_o), .info_i(lcd_info_o),
      .idx_o(lcd_idx_i), .seen_stamp_o(seen_stamp), .seen_info_o(seen_info));

   // 10 MHz clock
   always #50 clk_i = ~clk_i;
   // Hang guard; the full run needs well under 5000 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic logrd(input logic [6:0] n, output logic [31:0] s, output logic [15:0] i);
      logic [31:0] w;
      wr(`WEL_ADR_LIDX, {25'h0, n});
      rd(`WEL_ADR_LTIME, s);
      rd(`WEL_ADR_LINFO, w);
      i = w[15:0];
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      cyc(3);
      rst_n_i <= 1'b1;
      // Reset values and default-disabled checks
      #1 `CHK(thr_o, 16'h1405)
      rd(`WEL_ADR_CTRL, st);
      `CHK(st[6:0], 7'h08)
      rd(8'h3c, st);
      `CHK(st, 32'h0)
      @(posedge clk_i) src1_det_i <= 9'h005;
      cyc(6);
      #1 `CHK(popup_o, 1'b0)
      rd(`WEL_ADR_STAT, st);
      `CHK(st[30:24], 7'h00)
      @(posedge clk_i) src1_det_i <= 9'h000;
      wr(`WEL_ADR_CTRL, 32'h7f);
      wr(`WEL_ADR_THR, 32'h2a0b);
      #1 `CHK(thr_o, 16'h2a0b)
      $display("test reset done");
      // Every condition kind on both sources
      for (int s = 0; s < 2; s++) begin
         for (int r = 0; r < 9; r++) begin
            ec = rows[r].code + s[7:0];
            pe = rows[r].pop | (s == 1 && rows[r].kind == 4'd5);
            pc = (s == 1 && rows[r].kind == 4'd5) ? `WEL_C_GEN : ec;
            wr(`WEL_ADR_ACK, 32'h1);
            @(posedge clk_i) stamp_i <= {24'h0, ec};
            if (s == 0) src1_det_i[rows[r].kind] <= 1'b1;
            else src2_det_i[rows[r].kind] <= 1'b1;
            cyc(6);
            #1 `CHK(popup_o, pe)
            if (pe) `CHK(warn_code_o, pc)
            if (rows[r].led < 2'd2) `CHK(led_o[s], rows[r].led[0])
            if (rows[r].led == 2'd2) begin
               l0 = led_o[s];
               cyc(4);
               #1 `CHK(led_o[s], ~l0)
            end
            logrd(7'h00, st, inf);
            `CHK(inf[7:0], ec)
            `CHK(st, {24'h0, ec})
            `CHK(inf[15:12], 4'hd)
            @(posedge clk_i) src1_det_i <= 9'h000;
            src2_det_i <= 9'h000;
         end
      end
      // Unbalance on a disconnected source stays silent
      @(posedge clk_i) conn_i <= 2'h2;
      src1_det_i <= 9'h001;
      cyc(6);
      #1 `CHK(popup_o, 1'b0)
      @(posedge clk_i) src1_det_i <= 9'h000;
      conn_i <= 2'h3;
      $display("test table done");
      // Replacement, acknowledge, same-cycle ordering
      wr(`WEL_ADR_ACK, 32'h1);
      @(posedge clk_i) test_fail_i <= 2'h1;
      cyc(3);
      test_fail_i <= 2'h3;
      cyc(3);
      #1 `CHK(warn_code_o, 8'h29)
      wr(`WEL_ADR_ACK, 32'h1);
      cyc(1);
      #1 `CHK(popup_o, 1'b0)
      @(posedge clk_i) test_fail_i <= 2'h0;
      cyc(2);
      test_fail_i <= 2'h3;
      cyc(4);
      #1 `CHK(warn_code_o, `WEL_C_TEST)
      logrd(7'h00, st, inf);
      `CHK(inf[7:0], 8'h29)
      logrd(7'h01, st, inf);
      `CHK(inf[7:0], `WEL_C_TEST)
      @(posedge clk_i) test_fail_i <= 2'h0;
      wr(`WEL_ADR_ACK, 32'h1);
      $display("test warnings done");
      // Generator ready timeout, gated by auxiliary power
      @(posedge clk_i) gen_start_i <= 1'b1;
      cyc(40);
      #1 `CHK(popup_o, 1'b0)
      @(posedge clk_i) aux_pwr_i <= 1'b1;
      cyc(30);
      #1 `CHK(warn_code_o, 8'h1f)
      `CHK(popup_o, 1'b1)
      @(posedge clk_i) src1_det_i <= 9'h100;
      cyc(4);
      #1 `CHK(popup_o, 1'b0)
      @(posedge clk_i) gen_start_i <= 1'b0;
      $display("test generator done");
      // Fill past the log depth, then look at both read paths
      for (int k = 0; k < 120; k++) begin
         @(posedge clk_i) stamp_i <= k;
         test_fail_i <= 2'h1;
         @(posedge clk_i) test_fail_i <= 2'h0;
         cyc(2);
      end
      rd(`WEL_ADR_STAT, st);
      `CHK(st[30:24], 7'd99)
      logrd(7'd98, st, inf);
      `CHK(st, 32'd21)
      logrd(7'd99, st, inf);
      `CHK(inf, 16'h0)
      @(posedge clk_i) want <= 7'd19;
      cyc(4);
      #1 `CHK(seen_stamp, 32'd100)
      @(posedge clk_i) want <= 7'd20;
      cyc(4);
      #1 `CHK(seen_info, 16'h0)
      $display("test log done");
      // Mid-run reset empties the log and restores the defaults
      @(posedge clk_i) rst_n_i <= 1'b0;
      cyc(3);
      rst_n_i <= 1'b1;
      #1 `CHK(thr_o, 16'h1405)
      rd(`WEL_ADR_STAT, st);
      `CHK(st, 32'h0)
      $display("test reset again done");
      tally_and_finish();
   end
endmodule // warning_event_logger_bench

/* File: sim/wel_panel_model.sv */
// Display-side reader model that scrolls through the newest log entries
`timescale 1ns/1ps
module wel_panel_model (
   input  wire logic        clk_i,        // Clock
   input  wire logic [6:0]  want_i,       // Entry the operator scrolls to
   input  wire logic [31:0] stamp_i,      // Entry time from the logger
   input  wire logic [15:0] info_i,       // Entry info from the logger
   output logic      [6:0]  idx_o,        // Entry index towards the logger
   output logic      [31:0] seen_stamp_o, // Time as shown
   output logic      [15:0] seen_info_o   // Info as shown
);
   // Index is known at time zero so the logger never sees an unknown
   initial idx_o = 7'h00;
   // Request moves after the edge; shown values lag one edge, like a real panel refresh
   always @(posedge clk_i) begin
      idx_o        <= want_i;
      seen_stamp_o <= stamp_i;
      seen_info_o  <= info_i;
   end
endmodule // wel_panel_model

/* File: verilog/wel_pkg.sv */
// Types shared by the event logger modules
package wel_pkg;
   typedef enum logic [1:0] {LED_ON, LED_OFF, LED_BLINK} wel_led_t;
   typedef struct packed {
      logic        valid;
      logic [31:0] stamp;
      logic [3:0]  stat;
      logic [7:0]  code;
      logic [2:0]  mode;
   } wel_entry_t;
endpackage

/* File: verilog/wel_regs.svh */
// Register offsets, field positions, reset values, codes and timing of the event logger
`ifndef WEL_REGS_SVH
`define WEL_REGS_SVH
// Register byte offsets
`define WEL_ADR_CTRL  8'h00
`define WEL_ADR_THR   8'h04
`define WEL_ADR_ACK   8'h08
`define WEL_ADR_STAT  8'h0c
`define WEL_ADR_LIDX  8'h10
`define WEL_ADR_LTIME 8'h14
`define WEL_ADR_LINFO 8'h18
// Control bits
`define WEL_EN_UNBAL  0
`define WEL_EN_GENINV 1
`define WEL_EN_GENFL  2
`define WEL_EN_NPOS   3
`define WEL_EN_NLOSS  4
`define WEL_EN_OVOLT  5
`define WEL_EN_FREQ   6
`define WEL_CTRL_RST  7'h08
// Threshold reset values, percent
`define WEL_UNBAL_PCT 8'h05
`define WEL_NLOSS_PCT 8'h14
// Condition kinds per source
`define WEL_K_UNBAL   0
`define WEL_K_NPOS    1
`define WEL_K_NLOSS   2
`define WEL_K_UV      3
`define WEL_K_OV      4
`define WEL_K_NV      5
`define WEL_K_UF      6
`define WEL_K_OF      7
`define WEL_K_NORM    8
`define WEL_BLINK_MSK 9'h0dc
// Event slots, lowest code first
`define WEL_SLOTS     22
`define WEL_SLOT_TEST 2
`define WEL_SLOT_WARN 4
`define WEL_SLOT_POP  8
`define WEL_SLOT_SRC  10
`define WEL_C_GEN     8'h1e
`define WEL_C_TEST    8'h28
`define WEL_C_WARN    8'h32
`define WEL_C_SRC     8'h46
// Log sizes and timing
`define WEL_LOG_DEPTH 99
`define WEL_LCD_N     20
`define WEL_CLK_HZ    10000000
`define WEL_GEN_TMO_MS 10000
`define WEL_BLINK_MS  500
`endif

/* File: verilog/wel_src.sv */
// Edge detection and LED state for one source
`timescale 1ns/1ps
`include "wel_regs.svh"
module wel_src (
   input  wire logic clk_i,   // Clock
   input  wire logic rst_n_i, // Sync reset
   wel_src_if.src    s        // Conditions and events
);
   typedef struct packed {
      logic [8:0]        prev;
      logic [8:0]        evt;
      wel_pkg::wel_led_t led;
   } wel_src_st_t;
   wel_src_st_t st_r, st_nxt;
   logic [8:0]  act;

   // Enabled levels; unbalance and neutral loss only count while connected
   always_comb begin
      act                = s.det & s.en;
      act[`WEL_K_UNBAL]  = act[`WEL_K_UNBAL] & s.conn;
      act[`WEL_K_NLOSS]  = act[`WEL_K_NLOSS] & s.conn;
      st_nxt             = st_r;
      st_nxt.prev        = act;
      st_nxt.evt         = act & ~st_r.prev;
      if (act[`WEL_K_NV]) begin
         st_nxt.led = wel_pkg::LED_OFF;
      end else if (|(act & `WEL_BLINK_MSK)) begin
         st_nxt.led = wel_pkg::LED_BLINK;
      end else if (act[`WEL_K_NORM]) begin
         st_nxt.led = wel_pkg::LED_ON;
      end
   end

   // Prev resets high so levels present at start log nothing
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r      <= '0;
         st_r.prev <= '1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s.evt = st_r.evt;
   assign s.led = st_r.led;

   property p_nv_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      act[`WEL_K_NV] |=> st_r.led == wel_pkg::LED_OFF;
   endproperty
   a_nv_off: assert property (p_nv_off) else $error("no-voltage LED not off");
   property p_norm_on;
      @(posedge clk_i) disable iff (!rst_n_i)
      act[`WEL_K_NORM] && !act[`WEL_K_NV] && !(|(act & `WEL_BLINK_MSK)) |=> st_r.led == wel_pkg::LED_ON;
   endproperty
   a_norm_on: assert property (p_norm_on) else $error("recovered LED not on");
endmodule // wel_src

/* File: verilog/wel_src_if.sv */
// Per-source conditions in, events and LED state out
`timescale 1ns/1ps
interface wel_src_if;
   logic [8:0]        det;  // Condition levels
   logic              conn; // Source connected
   logic [8:0]        en;   // Per-kind enables
   logic [8:0]        evt;  // One-cycle event pulses
   wel_pkg::wel_led_t led;  // LED state
   modport src (input det, conn, en, output evt, led);
   modport top (output det, conn, en, input evt, led);
endinterface

/* File: verilog/wel_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module wel_sync #(
   parameter int W = 2 // Width
) (
   input  wire logic         clk_i,   // Clock
   input  wire logic         rst_n_i, // Sync reset
   input  wire logic [W-1:0] d_i,     // Async levels
   output logic      [W-1:0] q_o      // Synchronised
);
   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } wel_sync_st_t;
   wel_sync_st_t st_r, st_nxt;

   if (W < 1) begin : g_bad
      $error("wel_sync width must be positive");
   end

   // First stage feeds only the second
   always_comb begin
      st_nxt     = st_r;
      st_nxt.ff1 = d_i;
      st_nxt.ff2 = st_r.ff1;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign q_o = st_r.ff2;
endmodule // wel_sync

/* File: verilog/wel_top.sv */
// Warning and event manager with circular event log
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "wel_regs.svh"
// What this block does
// - Codes 30, 31, 40, 41, 50 to 53 raise the panel pop-up.
// - Codes 54, 55, 70 to 73, 76 to 79 only blink the source LED.
// - Codes 74 and 75 turn that source LED steadily off.
// - Source back to normal logs 80 or 81, LED steadily on.
// - New warning replaces the shown one; every warning is logged.
// - Warning acknowledge clears the active warning indication.
// - Warnings never block source transfer.
// - Enabled unbalance on a connected source raises 50 or 51.
// - Sudden alternate source loss raises 30 when enabled.
// - Generator not ready at ready-timeout raises 31 when enabled.
// - Generator start failure clears when either source is in range.
// - Ready timer runs only with auxiliary power present.
// - Failed or interrupted load tests always raise 40 or 41.
// - Enabled wrong neutral position raises 52 or 53.
// - Enabled neutral loss above 20 percent unbalance on a connected source logs 54 or 55.
// - Under-voltage always logs 70 or 71.
// - Enabled over-voltage logs 72 or 73.
// - No voltage always logs 74 or 75.
// - Enabled under/over-frequency logs 76, 77, 78, 79.
// - Log holds 99 entries, overwriting the oldest when full.
// - Display path sees the 20 newest, register path all entries.
// - Entry keeps time, source status, code, mode; only reset clears it.
module wel_top #(
   parameter int unsigned DEPTH     = `WEL_LOG_DEPTH,                           // Log entries
   parameter int unsigned LCD_N     = `WEL_LCD_N,                               // Display window
   parameter int unsigned GEN_CYC   = `WEL_GEN_TMO_MS * (`WEL_CLK_HZ / 1000),   // Ready timeout
   parameter int unsigned BLINK_CYC = `WEL_BLINK_MS * (`WEL_CLK_HZ / 1000)      // Blink half period
) (
   input  wire logic        clk_i,       // Clock, 10 MHz
   input  wire logic        rst_n_i,     // Sync reset
   input  wire logic [7:0]  addr_i,      // Register address
   input  wire logic [31:0] wdata_i,     // Write data
   input  wire logic        wr_i,        // Write strobe
   input  wire logic        rd_i,        // Read strobe
   output logic      [31:0] rdata_o,     // Read data
   input  wire logic [8:0]  src1_det_i,  // First source conditions
   input  wire logic [8:0]  src2_det_i,  // Second source conditions
   input  wire logic [1:0]  conn_i,      // Source connected
   input  wire logic [1:0]  test_fail_i, // On/off load test failed
   input  wire logic        gen_start_i, // Generator start asserted
   input  wire logic        gen_rdy_i,   // Generator ready pin
   input  wire logic        aux_pwr_i,   // Auxiliary power pin
   input  wire logic [31:0] stamp_i,     // Current time
   input  wire logic [2:0]  mode_i,      // Transfer mode
   input  wire logic [6:0]  lcd_idx_i,   // Display entry, 0 newest
   output logic             popup_o,     // Warning pop-up active
   output logic      [7:0]  warn_code_o, // Shown warning code
   output logic      [1:0]  led_o,       // Source green LEDs
   output logic      [15:0] thr_o,       // Neutral-loss, unbalance thresholds
   output logic      [31:0] lcd_stamp_o, // Display entry time
   output logic      [15:0] lcd_info_o   // Display entry info
);
   localparam int NS = `WEL_SLOTS;

   typedef struct packed {
      logic [6:0]                      ctrl;
      logic [15:0]                     thr;
      logic [6:0]                      lidx;
      logic [31:0]                     rdata;
      logic [NS-1:0]                   pend;
      logic [1:0]                      test_q;
      logic                            popup;
      logic [7:0]                      wcode;
      logic [31:0]                     gtmr;
      logic                            gdone;
      logic [6:0]                      head;
      logic [6:0]                      cnt;
      logic [31:0]                     btmr;
      logic                            bph;
      logic [1:0]                      led;
      logic [31:0]                     lcd_stamp;
      logic [15:0]                     lcd_info;
      wel_pkg::wel_entry_t [DEPTH-1:0] log;
   } wel_top_st_t;

   wel_top_st_t         st_r, st_nxt;
   logic [1:0]          pin_s;
   logic [8:0]          src_evt [2];
   wel_pkg::wel_led_t   src_led [2];
   logic [NS-1:0]       newev;
   logic                gto;
   logic                hit;
   int                  gidx;
   int                  pidx;
   logic                pop_new;
   logic                ack;
   logic                s_in;
   logic [6:0]          rd_pos;
   logic [6:0]          lc_pos;
   wel_pkg::wel_entry_t rd_ent;
   wel_pkg::wel_entry_t lc_ent;
   logic [8:0]          en;

   if (DEPTH < 1 || DEPTH > 127 || LCD_N > DEPTH || GEN_CYC < 1 || BLINK_CYC < 1) begin : g_bad
      $error("wel_top parameters out of range");
   end

   // Code of an event slot
   function automatic logic [7:0] slot_code(input int s);
      if (s < `WEL_SLOT_TEST) return `WEL_C_GEN + 8'(s);
      if (s < `WEL_SLOT_WARN) return `WEL_C_TEST + 8'(s - `WEL_SLOT_TEST);
      if (s < `WEL_SLOT_SRC) return `WEL_C_WARN + 8'(s - `WEL_SLOT_WARN);
      return `WEL_C_SRC + 8'(s - `WEL_SLOT_SRC);
   endfunction

   // Ring slot of the n-th newest entry
   function automatic logic [6:0] ring_pos(input logic [6:0] h, input logic [6:0] n);
      logic [7:0] t;
      t = {1'b0, h} + 8'(DEPTH - 1) - {1'b0, n};
      if (t >= 8'(DEPTH)) t = t - 8'(DEPTH);
      return t[6:0];
   endfunction

   // Pins from outside the clock domain
   wel_sync #(.W(2)) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({aux_pwr_i, gen_rdy_i}),
      .q_o     (pin_s)
   );

   // Per-kind enables; always-on kinds tied high
   assign en = {1'b1, st_r.ctrl[`WEL_EN_FREQ], st_r.ctrl[`WEL_EN_FREQ], 1'b1,
                st_r.ctrl[`WEL_EN_OVOLT], 1'b1, st_r.ctrl[`WEL_EN_NLOSS],
                st_r.ctrl[`WEL_EN_NPOS], st_r.ctrl[`WEL_EN_UNBAL]};

   // One monitor per source
   wel_src_if sif[2] ();
   for (genvar g = 0; g < 2; g++) begin : g_src
      assign sif[g].det  = (g == 0) ? src1_det_i : src2_det_i;
      assign sif[g].conn = conn_i[g];
      assign sif[g].en   = en;
      assign src_evt[g]  = sif[g].evt;
      assign src_led[g]  = sif[g].led;
      wel_src u_src (
         .clk_i   (clk_i),
         .rst_n_i (rst_n_i),
         .s       (sif[g])
      );
   end

   assign ack  = wr_i && addr_i == `WEL_ADR_ACK && wdata_i[0];
   assign s_in = src1_det_i[`WEL_K_NORM] | src2_det_i[`WEL_K_NORM];

   // Event collection, arbitration and pop-up selection
   always_comb begin
      newev = '0;
      gto   = 1'b0;
      newev[0] = st_r.ctrl[`WEL_EN_GENINV] & src_evt[1][`WEL_K_NV];
      if (!gen_start_i) begin
         gto = 1'b0;
      end else if (pin_s[1] && !pin_s[0] && !st_r.gdone && st_r.ctrl[`WEL_EN_GENFL]) begin
         gto = st_r.gtmr >= 32'(GEN_CYC - 1);
      end
      newev[1] = gto;
      newev[`WEL_SLOT_TEST +: 2] = test_fail_i & ~st_r.test_q;
      for (int j = 0; j < 9; j++) begin
         newev[`WEL_SLOT_WARN + 2 * j]     = src_evt[0][j];
         newev[`WEL_SLOT_WARN + 2 * j + 1] = src_evt[1][j];
      end
      // Downward scan leaves the lowest pending slot
      gidx = 0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (st_r.pend[i]) gidx = i;
      end
      hit  = |st_r.pend;
      pidx = 0;
      for (int i = `WEL_SLOT_POP - 1; i >= 0; i--) begin
         if (newev[i]) pidx = i;
      end
      pop_new = |newev[`WEL_SLOT_POP-1:0];
   end

   // Register and display read selection
   always_comb begin
      rd_pos = ring_pos(st_r.head, st_r.lidx);
      lc_pos = ring_pos(st_r.head, lcd_idx_i);
      rd_ent = (st_r.lidx < st_r.cnt) ? st_r.log[rd_pos] : '0;
      lc_ent = (32'(lcd_idx_i) < LCD_N && lcd_idx_i < st_r.cnt) ? st_r.log[lc_pos] : '0;
   end

   // Next state
   always_comb begin
      st_nxt        = st_r;
      st_nxt.test_q = test_fail_i;
      // Ready timer; holds without auxiliary power
      if (!gen_start_i) begin
         st_nxt.gtmr  = '0;
         st_nxt.gdone = 1'b0;
      end else if (gto) begin
         st_nxt.gdone = 1'b1;
      end else if (pin_s[1] && !pin_s[0] && !st_r.gdone && st_r.ctrl[`WEL_EN_GENFL]) begin
         st_nxt.gtmr = st_r.gtmr + 32'h1;
      end
      // Set wins over grant so no event is lost
      st_nxt.pend = (st_r.pend & ~(NS'(hit) << gidx)) | newev;
      if (hit) begin
         st_nxt.log[st_r.head].valid = 1'b1;
         st_nxt.log[st_r.head].stamp = stamp_i;
         st_nxt.log[st_r.head].stat  = {conn_i, src2_det_i[`WEL_K_NORM], src1_det_i[`WEL_K_NORM]};
         st_nxt.log[st_r.head].code  = slot_code(gidx);
         st_nxt.log[st_r.head].mode  = mode_i;
         st_nxt.head = (st_r.head == 7'(DEPTH - 1)) ? 7'h00 : st_r.head + 7'h01;
         if (st_r.cnt < 7'(DEPTH)) st_nxt.cnt = st_r.cnt + 7'h01;
      end
      // Pop-up: raise wins over acknowledge; no transfer interlock is driven
      if (pop_new) begin
         st_nxt.popup = 1'b1;
         st_nxt.wcode = slot_code(pidx);
      end else if (ack) begin
         st_nxt.popup = 1'b0;
      end else if (st_r.wcode == slot_code(1) && s_in) begin
         st_nxt.popup = 1'b0;
      end
      // Register writes
      if (wr_i) begin
         unique case (addr_i)
            `WEL_ADR_CTRL: st_nxt.ctrl = wdata_i[6:0];
            `WEL_ADR_THR:  st_nxt.thr  = wdata_i[15:0];
            `WEL_ADR_LIDX: st_nxt.lidx = wdata_i[6:0];
            default:       st_nxt.ctrl = st_r.ctrl;
         endcase
      end
      // Read data stand for one cycle only
      st_nxt.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            `WEL_ADR_CTRL:  st_nxt.rdata = {25'h0, st_r.ctrl};
            `WEL_ADR_THR:   st_nxt.rdata = {16'h0, st_r.thr};
            `WEL_ADR_STAT:  st_nxt.rdata = {1'b0, st_r.cnt, 1'b0, st_r.head, st_r.wcode, 7'h0, st_r.popup};
            `WEL_ADR_LIDX:  st_nxt.rdata = {25'h0, st_r.lidx};
            `WEL_ADR_LTIME: st_nxt.rdata = rd_ent.stamp;
            `WEL_ADR_LINFO: st_nxt.rdata = {16'h0, rd_ent.valid, rd_ent.mode, rd_ent.stat, rd_ent.code};
            default:        st_nxt.rdata = '0;
         endcase
      end
      // Display path, registered
      st_nxt.lcd_stamp = lc_ent.stamp;
      st_nxt.lcd_info  = {lc_ent.valid, lc_ent.mode, lc_ent.stat, lc_ent.code};
      // Blink phase shared by both LEDs
      if (st_r.btmr >= 32'(BLINK_CYC - 1)) begin
         st_nxt.btmr = '0;
         st_nxt.bph  = ~st_r.bph;
      end else begin
         st_nxt.btmr = st_r.btmr + 32'h1;
      end
      for (int g = 0; g < 2; g++) begin
         unique case (src_led[g])
            wel_pkg::LED_ON:    st_nxt.led[g] = 1'b1;
            wel_pkg::LED_OFF:   st_nxt.led[g] = 1'b0;
            wel_pkg::LED_BLINK: st_nxt.led[g] = st_r.bph;
            default:            st_nxt.led[g] = 1'b0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r      <= '0;
         st_r.ctrl <= `WEL_CTRL_RST;
         st_r.thr  <= {`WEL_NLOSS_PCT, `WEL_UNBAL_PCT};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata_o     = st_r.rdata;
   assign popup_o     = st_r.popup;
   assign warn_code_o = st_r.wcode;
   assign led_o       = st_r.led;
   assign thr_o       = st_r.thr;
   assign lcd_stamp_o = st_r.lcd_stamp;
   assign lcd_info_o  = st_r.lcd_info;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_ack_only;
      ack && !pop_new;
   endsequence
   sequence s_gen_logged;
      st_r.pend[1] ##[0:21] (hit && gidx == 1);
   endsequence

   property p_pop_raise;
      pop_new |=> popup_o && warn_code_o == $past(slot_code(pidx));
   endproperty
   a_pop_raise: assert property (p_pop_raise) else $error("warning not shown");
   property p_pop_cause;
      $rose(popup_o) |-> $past(pop_new);
   endproperty
   a_pop_cause: assert property (p_pop_cause) else $error("pop-up without warning");
   property p_ack;
      s_ack_only |=> !popup_o;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge ignored");
   property p_gen_clr;
      popup_o && warn_code_o == slot_code(1) && s_in && !pop_new |=> !popup_o;
   endproperty
   a_gen_clr: assert property (p_gen_clr) else $error("start failure not cleared");
   property p_gto;
      gto |=> s_gen_logged;
   endproperty
   a_gto: assert property (p_gto) else $error("start failure not logged");
   property p_aux;
      gen_start_i && !pin_s[1] |=> $stable(st_r.gtmr) && !$past(gto);
   endproperty
   a_aux: assert property (p_aux) else $error("timer ran without power");
   property p_log;
      hit |=> st_r.log[$past(st_r.head)].valid && st_r.log[$past(st_r.head)].code == $past(slot_code(gidx));
   endproperty
   a_log: assert property (p_log) else $error("entry not written");
   property p_wrap;
      hit && st_r.head == 7'(DEPTH - 1) |=> st_r.head == 7'h00 && st_r.cnt <= 7'(DEPTH);
   endproperty
   a_wrap: assert property (p_wrap) else $error("log did not wrap");
   property p_lcd;
      32'(lcd_idx_i) >= LCD_N |=> !lcd_info_o[15];
   endproperty
   a_lcd: assert property (p_lcd) else $error("display beyond window");
   // Shown code, test and alternate-loss capture, log size bound
   property p_code_quiet;
      $changed(warn_code_o) |-> $past(pop_new);
   endproperty
   a_code_quiet: assert property (p_code_quiet) else $error("shown code changed without warning");
   property p_test_pend;
      $rose(test_fail_i[0]) |=> st_r.pend[`WEL_SLOT_TEST];
   endproperty
   a_test_pend: assert property (p_test_pend) else $error("test failure not captured");
   property p_alt_pend;
      st_r.ctrl[`WEL_EN_GENINV] && src_evt[1][`WEL_K_NV] |=> st_r.pend[0];
   endproperty
   a_alt_pend: assert property (p_alt_pend) else $error("alternate loss not captured");
   property p_cnt_max;
      st_r.cnt <= 7'(DEPTH);
   endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("log count above depth");
endmodule // wel_top
